// [pgt_edge_capture.sv]
// Edge capture of one sensor port: pulse width or period events.
// Assumes the gate input is synchronous to ref_clk.
`timescale 1ns/1ps
module pgt_edge_capture #(
  parameter int AW = 6
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // Control
  input  wire logic             gateIn,
  input  wire logic             clear,
  input  wire logic             run,
  input  wire logic [7:0]       mode,
  input  wire logic             polLow,
  input  wire logic [pgt_pkg::TW-1:0] timer,
  // Results
  pgt_store_if.src              st,
  output logic [AW:0]           evCount,
  output logic                  newEvent
);
  localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

  logic                   blk;
  logic                   blkPrev_q;
  logic                   lead;
  logic                   trail;
  logic                   armed_q;
  logic                   done_q;
  logic                   isPulse;
  logic                   isPer;
  logic [pgt_pkg::TW-1:0] leadT_q;
  logic [pgt_pkg::TW-1:0] span;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on the blocked level
  assign blk     = (polLow == pgt_pkg::POL_LOW) ? !gateIn : gateIn; // RL2
  assign lead    = run && blk && !blkPrev_q;
  assign trail   = run && !blk && blkPrev_q;
  assign isPulse = (mode == pgt_pkg::MODE_PW_ONE) ||
                   (mode == pgt_pkg::MODE_PW_CONT);
  assign isPer   = (mode == pgt_pkg::MODE_PERIOD);
  assign span    = timer - leadT_q; // RL4

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      blkPrev_q <= 1'b0;
    end else begin
      blkPrev_q <= blk;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn || clear) begin
      armed_q <= 1'b0;
      leadT_q <= '0;
    end else if (lead) begin
      armed_q <= 1'b1;
      leadT_q <= timer;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Store one event per trailing edge (pulse) or per leading edge after the first (period)
  assign st.wrEn   = armed_q && (evCount != DEPTH) &&
                     ((isPulse && trail && !done_q) || (isPer && lead));
  assign st.wrAddr = evCount[AW-1:0];
  assign st.wrData = isPer ? {span, leadT_q} // RL9 RL10
                           : {span, timer};  // RL6
  assign newEvent  = st.wrEn;

  always_ff @(posedge ref_clk) begin
    if (!resetn || clear) begin
      done_q <= 1'b0;
    end else if (st.wrEn && mode == pgt_pkg::MODE_PW_ONE) begin
      done_q <= 1'b1; // RL1
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn || clear) begin
      evCount <= '0;
    end else if (st.wrEn) begin
      evCount <= evCount + 1'b1; // RL5
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_SINGLE_STOP: assert property ( // RL1
    done_q && mode == pgt_pkg::MODE_PW_ONE && !clear |-> !st.wrEn)
    else $error("single pulse mode stored a second event");
  AST_PULSE_TRAIL: assert property ( // RL6
    st.wrEn && isPulse |-> $past(blk) && !blk && st.wrData[31:0] == timer)
    else $error("pulse event not stored at trailing edge");
  AST_PERIOD_LEAD: assert property ( // RL9
    st.wrEn && isPer |-> blk && !$past(blk))
    else $error("period event not stored at blocking edge");
  AST_COUNT_STEP: assert property ( // RL5
    st.wrEn && !clear |=> evCount == $past(evCount) + 1'b1)
    else $error("event count did not advance by one");
  AST_IDLE_QUIET: assert property ( // RL13
    !run |-> !st.wrEn)
    else $error("event stored outside collection");
endmodule : pgt_edge_capture

// [pgt_event_mem.sv]
// Event store of one sensor port: width in the upper half, time below.
// Assumes one writer through the store interface; registered read.
`timescale 1ns/1ps
module pgt_event_mem #(
  parameter int W  = 64,
  parameter int AW = 6
) (
  // Clock
  input  wire logic          ref_clk,
  // Write side
  pgt_store_if.dst           st,
  // Read side
  input  wire logic [AW-1:0] rdAddr,
  output logic [W-1:0]       rdData
);
  logic [W-1:0] mem [1<<AW];

  always_ff @(posedge ref_clk) begin
    if (st.wrEn) begin
      mem[st.wrAddr] <= st.wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    rdData <= mem[rdAddr];
  end
endmodule : pgt_event_mem

// [pgt_gate_model.sv]
// Light gate stand-in for one sensor port: blocked request to pin level.
// Assumes the bench changes blockReq just after a rising edge of ref_clk.
`timescale 1ns/1ps
module pgt_gate_model (
  // Request
  input  wire logic blockReq,
  input  wire logic polLow,
  // Gate pin
  output logic      gate
);
  // Active-low gates read low while the beam is interrupted
  assign gate = blockReq ^ polLow;
endmodule : pgt_gate_model

// [pgt_photogate_capture.sv]
// Photogate timing capture for two sensor ports behind a register port.
// Assumes synchronous gate inputs and one software master on the port.
//
// How it works
// RL1: single pulse mode stops after one event
// RL2: mode 3 continuous; polarity 1 blocks low
// RL3: channel 41 is port one, 42 two
// RL4: width equals blocked duration
// RL5: sub-command 0 returns live event count
// RL6: store width and trailing-edge time
// RL7: sub-command -1 returns widths n..m, else all
// RL8: sub-command -2 returns trailing-edge times
// RL9: mode 4 measures blocking-to-blocking period
// RL10: period mode -2 returns period start times
// RL11: ports capture fully independently
// RL12: terminate ends collection on all ports
// RL13: collection ends after period times count
// RL14: host polls port one before port two
// RL15: capture runs only with analog channel active
// RL16: terminate keeps data and configuration
// RL17: indices are one-based in capture order
// RL18: one shared timer cleared at start
`timescale 1ns/1ps
module pgt_photogate_capture #(
  parameter int          AW       = 6,
  parameter logic [31:0] SPER_DEF = pgt_pkg::SPER_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Light gates
  input  wire logic        sensorPortOne,
  input  wire logic        sensorPortTwo,
  // Interrupt
  output logic             irq
);
  typedef enum logic {FE_IDLE, FE_RUN} pgt_fetch_t;

  localparam int NP   = pgt_pkg::NPORT;
  localparam int TW   = pgt_pkg::TW;
  localparam int IRQW = pgt_pkg::IRQ_W;

  logic [NP-1:0]        gates;
  logic [7:0]           mode_q [NP];
  logic [NP-1:0]        pol_q;
  logic [AW:0]          evCount [NP];
  logic [pgt_pkg::DW-1:0] memOut [NP];
  logic [AW-1:0]        rdAddr [NP];
  logic [NP-1:0]        newEv;
  logic                 run_q;
  logic                 ana_q;
  logic                 err_q;
  logic [TW-1:0]        timer_q;
  logic [31:0]          tick_q;
  logic [31:0]          samp_q;
  logic [31:0]          sper_q;
  logic [31:0]          scnt_q;
  logic [31:0]          range_q;
  logic [31:0]          result_q;
  logic [IRQW-1:0]      ist_q;
  logic [IRQW-1:0]      imsk_q;
  pgt_fetch_t           fe_q;
  logic                 fePort_q;
  logic                 feTime_q;
  logic [AW-1:0]        ptr_q;
  logic [AW-1:0]        last_q;

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  logic        wrCtrl;
  logic        wrCmd;
  logic        pop;
  logic        start;
  logic        term;
  logic        durDone;
  logic [7:0]  cmdCh;
  logic [7:0]  cmdOp;
  logic        chOk;
  logic        cmdPort;
  logic        isSetup;
  logic        isFetch;
  logic [15:0] rngN;
  logic [15:0] rngM;
  logic [15:0] cnt16;
  logic        allEv;
  logic        rngOk;

  assign wrCtrl  = regWr && regAddr == pgt_pkg::OFS_CTRL;
  assign wrCmd   = regWr && regAddr == pgt_pkg::OFS_CMD;
  assign pop     = regRd && regAddr == pgt_pkg::OFS_DATA && fe_q == FE_RUN;
  assign start   = wrCtrl && regWdata[pgt_pkg::CTRL_START];
  assign term    = wrCtrl && regWdata[pgt_pkg::CTRL_TERM];
  assign cmdCh   = regWdata[pgt_pkg::CMD_CH_LSB +: 8];
  assign cmdOp   = regWdata[pgt_pkg::CMD_OP_LSB +: 8];
  assign chOk    = cmdCh == pgt_pkg::CH_ONE || cmdCh == pgt_pkg::CH_TWO;
  assign cmdPort = cmdCh == pgt_pkg::CH_TWO; // RL3
  assign isSetup = cmdOp == pgt_pkg::MODE_OFF ? 1'b0 :
                   cmdOp == pgt_pkg::MODE_PW_ONE ||
                   cmdOp == pgt_pkg::MODE_PW_CONT ||
                   cmdOp == pgt_pkg::MODE_PERIOD;
  assign isFetch = cmdOp == pgt_pkg::OP_WIDTH || cmdOp == pgt_pkg::OP_TIME;
  assign rngN    = range_q[pgt_pkg::RNG_N_LSB +: 16];
  assign rngM    = range_q[pgt_pkg::RNG_M_LSB +: 16];
  assign cnt16   = 16'(evCount[cmdPort]);
  assign allEv   = rngN == 16'h0000 && rngM == 16'h0000; // RL7
  assign rngOk   = allEv ? cnt16 != 16'h0000
                         : rngN != 16'h0000 && rngN <= rngM && rngM <= cnt16;
  assign durDone = samp_q >= scnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Per-port capture and storage
  assign gates = {sensorPortTwo, sensorPortOne};

  for (genvar g = 0; g < NP; g++) begin : gPort
    pgt_store_if #(.W(pgt_pkg::DW), .AW(AW)) st ();
    // Next entry is addressed early so back-to-back pops see fresh data
    assign rdAddr[g] = (pop && fePort_q == 1'(g)) ? ptr_q + 1'b1 : ptr_q;
    pgt_edge_capture #(.AW(AW)) uCap (           // RL11
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .gateIn   (gates[g]),
      .clear    (start),
      .run      (run_q),
      .mode     (mode_q[g]),
      .polLow   (pol_q[g]),
      .timer    (timer_q),
      .st       (st.src),
      .evCount  (evCount[g]),
      .newEvent (newEv[g])
    );
    pgt_event_mem #(.W(pgt_pkg::DW), .AW(AW)) uMem (
      .ref_clk (ref_clk),
      .st      (st.dst),
      .rdAddr  (rdAddr[g]),
      .rdData  (memOut[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Port configuration
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_q <= '{default: pgt_pkg::MODE_OFF};
      pol_q  <= '0;
    end else if (wrCmd && chOk && isSetup) begin
      mode_q[cmdPort] <= cmdOp;                            // RL2 RL9
      pol_q[cmdPort]  <= regWdata[pgt_pkg::CMD_ARG_LSB];   // RL2
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Collection control, shared timer and duration
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      run_q <= 1'b0;
    end else if (term || (run_q && durDone)) begin
      run_q <= 1'b0; // RL12 RL13 RL16
    end else if (start && regWdata[pgt_pkg::CTRL_ANA]) begin
      // Analog enable must arrive in the same write as start
      run_q <= 1'b1; // RL15
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      timer_q <= '0;
      tick_q  <= '0;
      samp_q  <= '0;
    end else if (start) begin
      timer_q <= '0; // RL18
      tick_q  <= '0;
      samp_q  <= '0;
    end else if (run_q) begin
      timer_q <= timer_q + 1'b1;
      if (tick_q + 1'b1 >= sper_q) begin
        tick_q <= '0;
        samp_q <= samp_q + 1'b1; // RL13
      end else begin
        tick_q <= tick_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ana_q   <= 1'b0;
      sper_q  <= SPER_DEF;
      scnt_q  <= 32'(pgt_pkg::SCNT_RST);
      range_q <= '0;
      imsk_q  <= '0;
    end else if (regWr) begin
      unique case (regAddr)
        pgt_pkg::OFS_CTRL:  ana_q   <= regWdata[pgt_pkg::CTRL_ANA];
        pgt_pkg::OFS_SPER:  sper_q  <= regWdata;
        pgt_pkg::OFS_SCNT:  scnt_q  <= regWdata;
        pgt_pkg::OFS_RANGE: range_q <= regWdata;
        pgt_pkg::OFS_IMSK:  imsk_q  <= regWdata[IRQW-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Queries and range retrieval
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      result_q <= '0;
      err_q    <= 1'b0;
    end else if (wrCmd) begin
      err_q <= !chOk || !(isSetup || isFetch || cmdOp == pgt_pkg::OP_COUNT)
               || (isFetch && !rngOk);
      if (chOk && cmdOp == pgt_pkg::OP_COUNT) begin
        result_q <= 32'(evCount[cmdPort]); // RL5
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fe_q     <= FE_IDLE;
      fePort_q <= 1'b0;
      feTime_q <= 1'b0;
      ptr_q    <= '0;
      last_q   <= '0;
    end else if (wrCmd && chOk && isFetch) begin
      fe_q     <= rngOk ? FE_RUN : FE_IDLE;
      fePort_q <= cmdPort;
      feTime_q <= cmdOp == pgt_pkg::OP_TIME; // RL8 RL10
      ptr_q    <= allEv ? '0 : AW'(rngN - 1'b1);         // RL17
      last_q   <= allEv ? AW'(cnt16 - 1'b1) : AW'(rngM - 1'b1); // RL7
    end else if (pop) begin
      unique case (fe_q)
        FE_IDLE: ;
        FE_RUN: begin
          if (ptr_q == last_q) begin
            fe_q <= FE_IDLE;
          end
          ptr_q <= ptr_q + 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over write-one-to-clear
  logic [IRQW-1:0] irqSet;
  assign irqSet = {run_q && (term || durDone), newEv};

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ist_q <= '0;
    end else begin
      ist_q <= (ist_q & ~((regWr && regAddr == pgt_pkg::OFS_IST)
                          ? regWdata[IRQW-1:0] : '0)) | irqSet;
    end
  end

  assign irq = |(ist_q & imsk_q);

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      regRdata <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        pgt_pkg::OFS_CTRL:   regRdata <= 32'({ana_q, 1'b0, run_q});
        pgt_pkg::OFS_RANGE:  regRdata <= range_q;
        pgt_pkg::OFS_DATA:   regRdata <= (fe_q != FE_RUN) ? '0 :
                               feTime_q ? memOut[fePort_q][TW-1:0]
                                        : memOut[fePort_q][2*TW-1:TW];
        pgt_pkg::OFS_STATUS: regRdata <= 32'({err_q, fe_q == FE_RUN, run_q});
        pgt_pkg::OFS_RESULT: regRdata <= result_q;
        pgt_pkg::OFS_SPER:   regRdata <= sper_q;
        pgt_pkg::OFS_SCNT:   regRdata <= scnt_q;
        pgt_pkg::OFS_IST:    regRdata <= 32'(ist_q);
        pgt_pkg::OFS_IMSK:   regRdata <= 32'(imsk_q);
        default:             regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_TERM_STOPS: assert property ( // RL12
    term |=> !run_q)
    else $error("terminate did not end collection");
  AST_TERM_KEEPS: assert property ( // RL16
    term && !start && newEv == '0
    |=> evCount[0] == $past(evCount[0]) &&
                       evCount[1] == $past(evCount[1]) &&
                       mode_q[0] == $past(mode_q[0]))
    else $error("terminate disturbed stored events or setup");
  AST_ANALOG_GATE: assert property ( // RL15
    $rose(run_q) |-> ana_q && $past(start))
    else $error("collection started without an analog channel");
  AST_TIMER_CLEAR: assert property ( // RL18
    start |=> timer_q == '0 ##1 timer_q == TW'(run_q))
    else $error("shared timer not cleared at start");
  AST_DURATION_END: assert property ( // RL13
    run_q && durDone && !start |=> !run_q)
    else $error("collection outlived its duration");
  AST_CHAN_TWO: assert property ( // RL3
    wrCmd && cmdCh == pgt_pkg::CH_TWO && isSetup
    |=> mode_q[1] == $past(cmdOp) && mode_q[0] == $past(mode_q[0]))
    else $error("channel 42 did not address port two");
  AST_COUNT_QUERY: assert property ( // RL5
    wrCmd && chOk && cmdOp == pgt_pkg::OP_COUNT
    |=> result_q == 32'($past(cmdPort) ? $past(evCount[1])
                                        : $past(evCount[0])))
    else $error("count query returned a wrong value");
  AST_ONE_BASED: assert property ( // RL17
    wrCmd && chOk && isFetch && rngOk && !allEv
    |=> ptr_q == AW'($past(rngN) - 1'b1))
    else $error("range start not one-based");
  AST_FETCH_ENDS: assert property ( // RL7
    pop && ptr_q == last_q |=> fe_q == FE_IDLE)
    else $error("retrieval ran past the last index");

  COV_TERM_RUN:  cover property (run_q ##1 term);
  COV_FETCH_ALL: cover property (wrCmd && isFetch && allEv && rngOk);
  COV_TWO_PORTS: cover property (newEv[0] ##[1:100] newEv[1]);
  COV_DUR_END:   cover property (run_q && durDone);
endmodule : pgt_photogate_capture

// [pgt_photogate_capture_bench.sv]
// Self-checking bench of the photogate capture block.
// Assumes the register port contract of the block; short sample period.
`timescale 1ns/1ps
module pgt_photogate_capture_bench;
  localparam logic [31:0] SPER = 32'h64;
  logic        ref_clk;
  logic        resetn;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic [31:0] regRdata;
  logic [31:0] d;
  logic [31:0] t1;
  logic        irq;
  logic        sensorPortOne;
  logic        sensorPortTwo;
  logic [1:0]  blk;
  logic [1:0]  pol;
  logic [31:0] ld[2][$];
  logic [31:0] tr[2][$];
  logic [31:0] got[$];
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          t0;

  pgt_photogate_capture #(.SPER_DEF(SPER)) u_pgt_photogate_capture (
    .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .sensorPortOne(sensorPortOne),
    .sensorPortTwo(sensorPortTwo), .irq(irq));
  pgt_gate_model u_pgt_gate_model_one (
    .blockReq(blk[0]), .polLow(pol[0]), .gate(sensorPortOne));
  pgt_gate_model u_pgt_gate_model_two (
    .blockReq(blk[1]), .polLow(pol[1]), .gate(sensorPortTwo));

  //////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask : rd

  task automatic cmd(input logic [7:0] ch, op, arg);
    wr(pgt_pkg::OFS_CMD, {8'h00, arg, op, ch});
  endtask : cmd

  task automatic count(input logic [7:0] ch, output logic [31:0] v);
    cmd(ch, pgt_pkg::OP_COUNT, 8'h00);
    rd(pgt_pkg::OFS_RESULT, v);
  endtask : count

  task automatic fetch(input logic [7:0] ch, op, input int n, m, k);
    logic [31:0] v;
    wr(pgt_pkg::OFS_RANGE, {16'(m), 16'(n)});
    cmd(ch, op, 8'h00);
    got.delete();
    repeat (k) begin
      rd(pgt_pkg::OFS_DATA, v);
      got.push_back(v);
    end
  endtask : fetch

  // Blocks port p for len cycles, then leaves it clear for gap cycles
  task automatic pulse(input int p, len, gap);
    @(posedge ref_clk);
    blk[p] <= 1'b1;
    ld[p].push_back(32'(cyc));
    repeat (len) @(posedge ref_clk);
    blk[p] <= 1'b0;
    tr[p].push_back(32'(cyc));
    repeat (gap) @(posedge ref_clk);
  endtask : pulse

  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hf5e3));
    resetn   = 1'b0;
    regWr    = 1'b0;
    regRd    = 1'b0;
    regAddr  = 8'h00;
    regWdata = 32'h0;
    blk      = 2'b00;
    pol      = 2'b01;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(pgt_pkg::OFS_CTRL, d);
    chk("ctrl reset", d, 32'h0);
    rd(pgt_pkg::OFS_SPER, d);
    chk("period reset", d, SPER);
    rd(pgt_pkg::OFS_SCNT, d);
    chk("count reset", d, 32'd1000);
    rd(8'h30, d);
    chk("unmapped", d, 32'h0);
    chk("irq reset", 32'(irq), 32'h0);
    wr(pgt_pkg::OFS_CTRL, 32'h1);
    rd(pgt_pkg::OFS_STATUS, d);
    chk("run without analog", 32'(d[0]), 32'h0);
    $display("test reset done");

    cmd(pgt_pkg::CH_ONE, pgt_pkg::MODE_PW_CONT, 8'h01);
    cmd(pgt_pkg::CH_TWO, pgt_pkg::MODE_PERIOD, 8'h00);
    wr(pgt_pkg::OFS_IMSK, 32'h1);
    wr(pgt_pkg::OFS_CTRL, 32'h5);
    for (int i = 0; i < 6; i++) pulse(0, $urandom % 8 + 2, 3);
    count(pgt_pkg::CH_TWO, d);
    chk("count two idle", d, 32'h0);
    for (int i = 0; i < 5; i++) pulse(1, $urandom % 8 + 2, $urandom % 5 + 2);
    count(pgt_pkg::CH_ONE, d);
    chk("count one", d, 32'd6);
    count(pgt_pkg::CH_TWO, d);
    chk("count two", d, 32'd4);
    chk("irq raised", 32'(irq), 32'h1);
    wr(pgt_pkg::OFS_IST, 32'h1);
    rd(pgt_pkg::OFS_IST, d);
    chk("status after clear", d, 32'h2);
    chk("irq masked", 32'(irq), 32'h0);
    $display("test capture done");

    fetch(pgt_pkg::CH_ONE, pgt_pkg::OP_WIDTH, 2, 5, 4);
    for (int i = 0; i < 4; i++)
      chk("width range", got[i], tr[0][i+1] - ld[0][i+1]);
    rd(pgt_pkg::OFS_DATA, d);
    chk("data after range", d, 32'h0);
    fetch(pgt_pkg::CH_ONE, pgt_pkg::OP_WIDTH, 0, 0, 6);
    for (int i = 0; i < 6; i++)
      chk("width all", got[i], tr[0][i] - ld[0][i]);
    fetch(pgt_pkg::CH_ONE, pgt_pkg::OP_TIME, 0, 0, 6);
    t1 = got[0];
    for (int i = 0; i < 6; i++)
      chk("end time", got[i] - t1, tr[0][i] - tr[0][0]);
    fetch(pgt_pkg::CH_TWO, pgt_pkg::OP_WIDTH, 0, 0, 4);
    for (int i = 0; i < 4; i++)
      chk("period", got[i], ld[1][i+1] - ld[1][i]);
    fetch(pgt_pkg::CH_TWO, pgt_pkg::OP_TIME, 0, 0, 4);
    for (int i = 0; i < 4; i++)
      chk("period start", got[i] - t1, ld[1][i] - tr[0][0]);
    fetch(pgt_pkg::CH_ONE, pgt_pkg::OP_WIDTH, 5, 2, 0);
    rd(pgt_pkg::OFS_STATUS, d);
    chk("bad range", 32'(d[2]), 32'h1);
    $display("test fetch done");

    wr(pgt_pkg::OFS_CTRL, 32'h6);
    pulse(0, 4, 3);
    rd(pgt_pkg::OFS_STATUS, d);
    chk("stopped", 32'(d[0]), 32'h0);
    count(pgt_pkg::CH_ONE, d);
    chk("kept count", d, 32'd6);
    rd(pgt_pkg::OFS_IST, d);
    chk("end event", 32'(d[2]), 32'h1);
    $display("test terminate done");

    wr(pgt_pkg::OFS_SCNT, 32'd10);
    cmd(pgt_pkg::CH_TWO, pgt_pkg::MODE_PW_ONE, 8'h00);
    wr(pgt_pkg::OFS_CTRL, 32'h5);
    t0 = cyc;
    pulse(1, 3, 3);
    pulse(1, 3, 3);
    count(pgt_pkg::CH_TWO, d);
    chk("single count", d, 32'd1);
    count(pgt_pkg::CH_ONE, d);
    chk("start clears", d, 32'h0);
    do rd(pgt_pkg::OFS_STATUS, d); while (d[0] && cyc - t0 < 1200);
    t0 = cyc - t0 - 10 * int'(SPER);
    chk("duration end", 32'(t0 >= -5 && t0 <= 10), 32'h1);
    $display("test duration done");
    close_out();
  end
endmodule : pgt_photogate_capture_bench

// [pgt_pkg.sv]
// Shared constants of the photogate timing capture block.
// Assumes a 32-bit register port with byte addresses on 8 bits.
package pgt_pkg;
  localparam int          NPORT        = 2;
  localparam int          TW           = 32;
  localparam int          DW           = 2 * TW;
  // Register offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_CMD      = 8'h04;
  localparam logic [7:0]  OFS_RANGE    = 8'h08;
  localparam logic [7:0]  OFS_DATA     = 8'h0c;
  localparam logic [7:0]  OFS_STATUS   = 8'h10;
  localparam logic [7:0]  OFS_RESULT   = 8'h14;
  localparam logic [7:0]  OFS_SPER     = 8'h18;
  localparam logic [7:0]  OFS_SCNT     = 8'h1c;
  localparam logic [7:0]  OFS_IST      = 8'h20;
  localparam logic [7:0]  OFS_IMSK     = 8'h24;
  // Field positions
  localparam int          CTRL_START   = 0;
  localparam int          CTRL_TERM    = 1;
  localparam int          CTRL_ANA     = 2;
  localparam int          CMD_CH_LSB   = 0;
  localparam int          CMD_OP_LSB   = 8;
  localparam int          CMD_ARG_LSB  = 16;
  localparam int          RNG_N_LSB    = 0;
  localparam int          RNG_M_LSB    = 16;
  localparam int          ST_RUN       = 0;
  localparam int          ST_FETCH     = 1;
  localparam int          ST_ERR       = 2;
  localparam int          IRQ_DONE     = 2;
  localparam int          IRQ_W        = 3;
  // Channel, mode and sub-command codes
  localparam logic [7:0]  CH_ONE       = 8'h29;
  localparam logic [7:0]  CH_TWO       = 8'h2a;
  localparam logic [7:0]  MODE_OFF     = 8'h00;
  localparam logic [7:0]  MODE_PW_ONE  = 8'h02;
  localparam logic [7:0]  MODE_PW_CONT = 8'h03;
  localparam logic [7:0]  MODE_PERIOD  = 8'h04;
  localparam logic [7:0]  OP_COUNT     = 8'h00;
  localparam logic [7:0]  OP_WIDTH     = 8'hff;
  localparam logic [7:0]  OP_TIME      = 8'hfe;
  localparam logic        POL_LOW      = 1'b1;
  // Timing: default sample period and sample count
  localparam int          CLK_HZ       = 25_000_000;
  localparam int          SPER_S       = 60;
  localparam int          SCNT_RST     = 1000;
  localparam logic [31:0] SPER_CYC     = 32'(SPER_S * CLK_HZ);
endpackage : pgt_pkg

// [pgt_store_if.sv]
// Write path from an edge capture unit into its event memory.
// Assumes both ends share ref_clk.
`timescale 1ns/1ps
interface pgt_store_if #(parameter int W = 64, parameter int AW = 6);
  logic          wrEn;
  logic [AW-1:0] wrAddr;
  logic [W-1:0]  wrData;
  modport src (output wrEn, output wrAddr, output wrData);
  modport dst (input wrEn, input wrAddr, input wrData);
endinterface : pgt_store_if
